// ---- core/temp_defs.svh ----
`ifndef TEMP_DEFS_SVH
`define TEMP_DEFS_SVH

// register pointers
`define PTR_RESET        8'h00
`define REG_TEMP_LAST    8'h04
`define REG_ALARM1       8'h21
`define REG_ALARM2       8'h22
`define REG_OPEN         8'h23
`define REG_CONFIG       8'h30
`define REG_HYS          8'h38
`define REG_LOCAL_THR1   8'h39
`define REG_LOCAL_THR2   8'h3A
`define THR_GRP_LO       5'h08
`define THR_GRP_HI       5'h0B
`define THR_SLOT         2'h1

// reset values and special codes
`define CFG_RESET        16'h0F9C
`define HYS_RESET        16'h0080
`define THR_RESET        16'h7FC0
`define TEMP_RESET       16'h0000
`define TEMP_OPEN        16'h8000

// field positions
`define CFG_EN_HI        11
`define CFG_EN_LO        7
`define CFG_ONESHOT      6
`define CFG_SHUTDOWN     5
`define CFG_RATE_HI      4
`define CFG_RATE_LO      2
`define CFG_BUSY         1
`define FLAG_HI          11
`define FLAG_LO          7
`define OPEN_HI          11
`define OPEN_LO          8
`define HYS_MSB          15

// serial framing
`define BYTE_BITS        4'h8

// conversion timing
`define RATE_NONE        3'h7
`define RATE_MAX_SHIFT   3'h6
`define QUARTER_NS       250000000
`define CLK_NS           50

`endif

// ---- core/temp_pkg.sv ----
package temp_pkg;

  typedef logic [15:0] word_t;

  typedef enum logic [2:0] {
    B_IDLE  = 3'h0,
    B_RX    = 3'h1,
    B_RXACK = 3'h2,
    B_TX    = 3'h3,
    B_TXACK = 3'h4
  } bus_e;

  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_PTR  = 2'h1,
    K_MSB  = 2'h2,
    K_LSB  = 2'h3
  } kind_e;

  typedef enum logic [1:0] {
    C_IDLE  = 2'h0,
    C_START = 2'h1,
    C_WAIT  = 2'h2,
    C_GAP   = 2'h3
  } conv_e;

  typedef struct packed {
    logic       start;
    logic [2:0] channel;
  } meas_req_s;

  typedef struct packed {
    logic  done;
    logic  probeOpen;
    word_t result;
  } meas_rsp_s;

  typedef struct packed {
    logic       found;
    logic [2:0] ch;
  } chan_sel_s;

  typedef struct packed {
    logic       hit;
    logic [3:0] idx;
  } thr_sel_s;

  typedef struct packed {
    bus_e             bus;
    kind_e            kind;
    logic [3:0]       bitCnt;
    logic [7:0]       sh;
    logic             rw;
    logic [7:0]       ptr;
    logic [7:0]       wrMsb;
    word_t            tx;
    logic             sdaOut;
    logic             sdaOe;
    logic             sclPrev;
    logic             sdaPrev;
    conv_e            conv;
    logic [2:0]       ch;
    logic [4:0]       en;
    logic             singleShot;
    logic             shutdown;
    logic [2:0]       rate;
    word_t            hys;
    logic [9:0][15:0] thr;
    logic [4:0][15:0] temp;
    logic [3:0]       open;
    logic [4:0]       alarm1;
    logic [4:0]       alarm2;
    logic [22:0]      tick;
    logic [6:0]       quarters;
    meas_req_s        req;
    logic             pin1Oe;
    logic             pin2Oe;
  } state_s;

endpackage

// ---- core/alarm_hyst.sv ----
`timescale 1ns/1ps
module alarm_hyst (
  input  wire logic        flag,
  input  wire logic [15:0] temp,
  input  wire logic [15:0] limit,
  input  wire logic [15:0] hys,
  output logic             flagNext
);
  logic signed [16:0] tempS;
  logic signed [16:0] limS;
  logic signed [16:0] lowS;

  // one extra bit so limit minus hysteresis cannot wrap
  assign tempS = $signed({temp[15], temp});
  assign limS  = $signed({limit[15], limit});
  assign lowS  = limS - $signed({1'b0, hys});

  always_comb begin
    flagNext = flag;
    if (tempS > limS) begin
      flagNext = 1'b1;
    end else if (tempS < lowS) begin
      flagNext = 1'b0;
    end
  end
endmodule

// ---- core/temp_sensor_status_config.sv ----
// Function
// - pointer is zero after reset so plain reads give local temperature
// - writes to unmapped pointers are acknowledged but change nothing
// - pointer byte is acknowledged even when the pointer is unmapped
// - first alarm flag sets when temperature exceeds first limit
// - flag clears only below limit minus shared hysteresis
// - second alarm flags behave alike with second limits
// - first alarm status: local at bit 7, remotes at 8 to 11
// - second alarm status uses the same bit positions
// - open probe on remote channel sets its bit at 8 to 11
// - open remote channel reports the most negative temperature code
// - open status reaches alarm pins only through the alarm flags
// - config enables at 11:8 and 7, all set after reset
// - one-shot bit 6, shutdown bit 5 clear; rate 4:2 resets to 111
// - busy bit 1 shows conversion in progress and ignores writes
// - continuous rounds run local then remote 1 through 4
// - disabled channels are skipped, others keep their order
// - all enables zero forces shutdown, reading one-shot 0 shutdown 1
// - mode from shutdown and one-shot; enables read back as written
// - rate selects 16 s down to 0.25 s gap; 111 gives none
// - hysteresis most significant bit always reads zero
`timescale 1ns/1ps
`include "temp_defs.svh"
module temp_sensor_status_config #(
  parameter logic [6:0] DEV_ADDR       = 7'h48,
  parameter int         QUARTER_CYCLES = `QUARTER_NS / `CLK_NS
) (
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               scl,
  input  wire logic               sdaIn,
  output logic                    sdaOut,
  output logic                    sdaOe,
  input  wire temp_pkg::meas_rsp_s measRsp,
  output temp_pkg::meas_req_s     measReq,
  output logic                    primaryAlarmOe,
  output logic                    secondaryAlarmOe
);
  import temp_pkg::*;

  localparam word_t CFG_POR = `CFG_RESET;
  localparam state_s RESET_STATE = '{
    bus:    B_IDLE,
    kind:   K_ADDR,
    ptr:    `PTR_RESET,
    conv:   C_IDLE,
    en:     CFG_POR[`CFG_EN_HI:`CFG_EN_LO],
    singleShot: CFG_POR[`CFG_ONESHOT],
    shutdown:   CFG_POR[`CFG_SHUTDOWN],
    rate:   CFG_POR[`CFG_RATE_HI:`CFG_RATE_LO],
    hys:    `HYS_RESET,
    thr:    {10{`THR_RESET}},
    temp:   {5{`TEMP_RESET}},
    default: '0
  };

  state_s     s;
  state_s     n;
  word_t      newTemp;
  logic [4:0] nxt1;
  logic [4:0] nxt2;
  logic       convDone;
  logic       wrStrobe;
  word_t      wrData;

  function automatic thr_sel_s thrSel(input logic [7:0] p);
    thrSel = '0;
    if (p == `REG_LOCAL_THR1 || p == `REG_LOCAL_THR2) begin
      thrSel.hit = 1'b1;
      // local first limit sits at the odd pointer, second at the even one
      thrSel.idx = {3'h0, ~p[0]};
    end else if (p[7:3] >= `THR_GRP_LO && p[7:3] <= `THR_GRP_HI &&
                 p[2:1] == `THR_SLOT) begin
      thrSel.hit = 1'b1;
      thrSel.idx = {3'(p[4:3] + 2'h1), p[0]};
    end
  endfunction

  function automatic chan_sel_s nextChan(input logic [4:0] en,
                                         input logic [2:0] from);
    nextChan = '0;
    for (int i = 4; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) begin
        nextChan.found = 1'b1;
        nextChan.ch    = 3'(i);
      end
    end
  endfunction

  function automatic word_t readReg(input state_s st, input logic [7:0] p);
    thr_sel_s ts;
    ts = thrSel(p);
    readReg = '0; // reserved and unmapped bits read zero
    if (p <= `REG_TEMP_LAST) begin
      readReg = st.temp[p[2:0]];
    end else if (p == `REG_ALARM1) begin
      readReg[`FLAG_HI:`FLAG_LO] = st.alarm1;
    end else if (p == `REG_ALARM2) begin
      readReg[`FLAG_HI:`FLAG_LO] = st.alarm2;
    end else if (p == `REG_OPEN) begin
      readReg[`OPEN_HI:`OPEN_LO] = st.open;
    end else if (p == `REG_CONFIG) begin
      readReg[`CFG_EN_HI:`CFG_EN_LO]     = st.en;
      readReg[`CFG_ONESHOT]              = st.singleShot;
      readReg[`CFG_SHUTDOWN]             = st.shutdown;
      readReg[`CFG_RATE_HI:`CFG_RATE_LO] = st.rate;
      readReg[`CFG_BUSY] = (st.conv == C_START) ||
                           (st.conv == C_WAIT);
    end else if (p == `REG_HYS) begin
      readReg = st.hys;
    end else if (ts.hit) begin
      readReg = st.thr[ts.idx];
    end
  endfunction

  // an open remote probe overrides whatever the converter measured
  assign convDone = (s.conv == C_WAIT) && measRsp.done;
  assign newTemp  = (s.ch != 3'h0 && measRsp.probeOpen) ?
                    `TEMP_OPEN : measRsp.result;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gAlarm
      alarm_hyst uFirst (
        .flag     (s.alarm1[g]),
        .temp     (newTemp),
        .limit    (s.thr[2*g]),
        .hys      (s.hys),
        .flagNext (nxt1[g])
      );
      alarm_hyst uSecond (
        .flag     (s.alarm2[g]),
        .temp     (newTemp),
        .limit    (s.thr[2*g+1]),
        .hys      (s.hys),
        .flagNext (nxt2[g])
      );
    end
  endgenerate

  always_comb begin
    word_t     rd;
    chan_sel_s sel;
    thr_sel_s  ts;
    logic      sclRise;
    logic      sclFall;
    logic      startC;
    logic      stopC;
    rd       = '0;
    sel      = '0;
    ts       = '0;
    wrStrobe = 1'b0;
    n        = s;
    n.req.start = 1'b0;
    sclRise  = scl & ~s.sclPrev;
    sclFall  = ~scl & s.sclPrev;
    startC   = scl & s.sclPrev & s.sdaPrev & ~sdaIn;
    stopC    = scl & s.sclPrev & ~s.sdaPrev & sdaIn;
    n.sclPrev = scl;
    n.sdaPrev = sdaIn;

    // serial slave: the pointer never auto-increments
    if (stopC) begin
      n.bus   = B_IDLE;
      n.sdaOe = 1'b0;
    end else if (startC) begin
      n.bus    = B_RX;
      n.kind   = K_ADDR;
      n.bitCnt = '0;
      n.sdaOe  = 1'b0;
    end else begin
      unique case (s.bus)
        B_IDLE: begin
        end
        B_RX: begin
          if (sclRise) begin
            n.sh     = {s.sh[6:0], sdaIn};
            n.bitCnt = s.bitCnt + 4'h1;
          end else if (sclFall && s.bitCnt == `BYTE_BITS) begin
            n.bus   = B_RXACK;
            n.sdaOe = 1'b1;
            unique case (s.kind)
              K_ADDR: begin
                n.rw = s.sh[0];
                if (s.sh[7:1] != DEV_ADDR) begin
                  n.bus   = B_IDLE;
                  n.sdaOe = 1'b0;
                end
              end
              K_PTR: n.ptr = s.sh; // acked whether mapped or not
              K_MSB: n.wrMsb = s.sh;
              K_LSB: wrStrobe = 1'b1; // acked before decoding
            endcase
          end
        end
        B_RXACK: begin
          if (sclFall) begin
            n.sdaOe  = 1'b0;
            n.bitCnt = '0;
            if (s.kind == K_ADDR && s.rw) begin
              rd      = readReg(s, s.ptr);
              n.tx    = rd;
              n.sh    = rd[15:8];
              n.sdaOe = ~rd[15];
              n.kind  = K_MSB;
              n.bus   = B_TX;
            end else begin
              n.bus  = B_RX;
              n.kind = (s.kind == K_LSB) ? K_MSB : kind_e'(s.kind + 2'h1);
            end
          end
        end
        B_TX: begin
          if (sclRise) begin
            n.bitCnt = s.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (s.bitCnt == `BYTE_BITS) begin
              n.sdaOe = 1'b0;
              n.bus   = B_TXACK;
            end else begin
              n.sdaOe = ~s.sh[6];
              n.sh    = {s.sh[6:0], 1'b0};
            end
          end
        end
        B_TXACK: begin
          if (sclRise && sdaIn) begin
            n.bus = B_IDLE;
          end else if (sclFall) begin
            n.bus    = B_TX;
            n.bitCnt = '0;
            if (s.kind == K_MSB) begin
              n.kind  = K_LSB;
              n.sh    = s.tx[7:0];
              n.sdaOe = ~s.tx[7];
            end else begin
              rd      = readReg(s, s.ptr);
              n.tx    = rd;
              n.kind  = K_MSB;
              n.sh    = rd[15:8];
              n.sdaOe = ~rd[15];
            end
          end
        end
        default: begin
          n.bus   = B_IDLE;
          n.sdaOe = 1'b0;
        end
      endcase
    end

    // conversion sequencer
    unique case (s.conv)
      C_IDLE: begin
        sel = nextChan(s.en, 3'h0);
        if (sel.found && (~s.shutdown || s.singleShot)) begin
          n.ch   = sel.ch; // lowest enabled first
          n.conv = C_START;
        end
      end
      C_START: begin
        if (s.en[s.ch]) begin
          n.req.start   = 1'b1;
          n.req.channel = s.ch;
          n.conv        = C_WAIT;
        end else begin
          n.conv = C_IDLE; // enable dropped meanwhile
        end
      end
      C_WAIT: begin
        if (measRsp.done) begin
          n.temp[s.ch]   = newTemp;
          n.alarm1[s.ch] = nxt1[s.ch];
          n.alarm2[s.ch] = nxt2[s.ch];
          if (s.ch != 3'h0) begin
            n.open[2'(s.ch - 3'h1)] = measRsp.probeOpen;
          end
          sel = nextChan(s.en, s.ch + 3'h1);
          if (sel.found) begin
            n.ch   = sel.ch;
            n.conv = C_START;
          end else if (s.shutdown) begin
            n.singleShot = 1'b0; // single round done
            n.conv       = C_IDLE;
          end else if (s.rate == `RATE_NONE) begin
            // no idle slot, so busy stays up between rounds
            sel    = nextChan(s.en, 3'h0);
            n.ch   = sel.ch;
            n.conv = C_START; // back to back rounds
          end else begin
            n.conv     = C_GAP;
            n.tick     = '0;
            n.quarters = 7'(7'h01 << (`RATE_MAX_SHIFT - s.rate));
          end
        end
      end
      C_GAP: begin
        if (s.tick == 23'(QUARTER_CYCLES - 1)) begin
          n.tick     = '0;
          n.quarters = s.quarters - 7'h01;
          if (s.quarters == 7'h01) begin
            n.conv = C_IDLE;
          end
        end else begin
          n.tick = s.tick + 23'h1;
        end
      end
    endcase

    // host write comes last so it wins over the sequencer's one-shot clear
    wrData = {s.wrMsb, s.sh};
    ts     = thrSel(s.ptr);
    if (wrStrobe) begin
      if (s.ptr == `REG_CONFIG) begin
        n.en   = wrData[`CFG_EN_HI:`CFG_EN_LO];
        n.rate = wrData[`CFG_RATE_HI:`CFG_RATE_LO];
        if (wrData[`CFG_EN_HI:`CFG_EN_LO] == 5'h00) begin
          n.shutdown   = 1'b1; // nothing to convert
          n.singleShot = 1'b0;
        end else begin
          n.shutdown   = wrData[`CFG_SHUTDOWN];
          n.singleShot = wrData[`CFG_ONESHOT];
        end
      end else if (s.ptr == `REG_HYS) begin
        n.hys = {1'b0, wrData[`HYS_MSB-1:0]};
      end else if (ts.hit) begin
        n.thr[ts.idx] = wrData;
      end
    end

    // pins see only the flags, never the open status
    n.pin1Oe = |n.alarm1;
    n.pin2Oe = |n.alarm2;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= RESET_STATE;
    end else begin
      s <= n;
    end
  end

  assign sdaOut           = s.sdaOut;
  assign sdaOe            = s.sdaOe;
  assign measReq          = s.req;
  assign primaryAlarmOe   = s.pin1Oe;
  assign secondaryAlarmOe = s.pin2Oe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic      startC_w;
  logic      stopC_w;
  chan_sel_s afterSel;
  thr_sel_s  ptrSel;
  assign startC_w = scl & s.sclPrev & s.sdaPrev & ~sdaIn;
  assign stopC_w  = scl & s.sclPrev & ~s.sdaPrev & sdaIn;
  assign afterSel = nextChan(s.en, s.ch + 3'h1);
  assign ptrSel   = thrSel(s.ptr);

  logic belowLow0;
  assign belowLow0 = $signed({newTemp[15], newTemp}) <
                     $signed({s.thr[0][15], s.thr[0]}) -
                     $signed({1'b0, s.hys});

  sequence oneShotLast;
    convDone && s.shutdown && !afterSel.found && !wrStrobe;
  endsequence

  chk_ptr_power_up: assert property (
    $rose(resetn) |-> s.ptr == `PTR_RESET)
    else $error("pointer not zero after reset");
  chk_unmapped_write: assert property (
    (wrStrobe && s.ptr != `REG_CONFIG && s.ptr != `REG_HYS &&
     !ptrSel.hit) |=> $stable(s.thr) && $stable(s.hys) &&
                             $stable(s.en) && $stable(s.rate))
    else $error("unmapped write changed state");
  chk_ptr_ack: assert property (
    (s.bus == B_RX && s.kind == K_PTR && !scl && s.sclPrev &&
     s.bitCnt == `BYTE_BITS && !startC_w && !stopC_w)
    |=> s.bus == B_RXACK && s.sdaOe)
    else $error("pointer byte not acknowledged");
  chk_alarm1_set: assert property (
    (convDone && s.ch == 3'h0 &&
     $signed(newTemp) > $signed(s.thr[0])) |=> s.alarm1[0] ##1 s.pin1Oe)
    else $error("first alarm did not set");
  chk_alarm1_clear: assert property (
    $fell(s.alarm1[0]) |-> $past(convDone && s.ch == 3'h0 && belowLow0))
    else $error("first alarm cleared above hysteresis band");
  chk_alarm2_set: assert property (
    (convDone && s.ch == 3'h0 &&
     $signed(newTemp) > $signed(s.thr[1])) |=> s.alarm2[0])
    else $error("second alarm did not set");
  chk_open_force: assert property (
    (convDone && s.ch == 3'h1 && measRsp.probeOpen)
    |=> s.temp[1] == `TEMP_OPEN && s.open[0])
    else $error("open probe not forced to minimum");
  chk_pin_flags: assert property (
    s.pin1Oe == |s.alarm1 && s.pin2Oe == |s.alarm2)
    else $error("alarm pin disagrees with flags");
  chk_skip_disabled: assert property (
    s.req.start |-> $past(s.en[s.ch]))
    else $error("disabled channel converted");
  chk_all_off: assert property (
    s.en == 5'h00 |-> s.shutdown && !s.singleShot)
    else $error("all channels off without shutdown");
  chk_oneshot_end: assert property (
    oneShotLast |=> !s.singleShot && s.conv == C_IDLE)
    else $error("one-shot round did not return to shutdown");
  chk_hys_msb: assert property (
    !s.hys[`HYS_MSB])
    else $error("hysteresis sign bit set");

endmodule

// ---- bench/conv_model.sv ----
`timescale 1ns/1ps
// converter stand-in: answers each start after a fixed delay
module conv_model #(
  parameter int DELAY = 6
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire temp_pkg::meas_req_s measReq,
  input  wire logic [4:0][15:0]    temps,
  input  wire logic [4:0]          opens,
  output temp_pkg::meas_rsp_s      measRsp
);
  import temp_pkg::*;
  int         cnt;
  logic [2:0] ch;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      ch <= 3'h0;
      measRsp <= '0;
    end else begin
      // outside done the result is scrambled so a stale read shows
      measRsp.done <= 1'b0;
      measRsp.result <= ~measRsp.result;
      measRsp.probeOpen <= ~measRsp.probeOpen;
      if (measReq.start) begin
        cnt <= DELAY;
        ch <= measReq.channel;
      end else if (cnt == 1) begin
        cnt <= 0;
        measRsp.done <= 1'b1;
        measRsp.result <= temps[ch];
        measRsp.probeOpen <= opens[ch];
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ---- bench/temp_sensor_status_config_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    nFail++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); \
  end \
end
module temp_sensor_status_config_tb;
  import temp_pkg::*;
  localparam logic [6:0] ADDR = 7'h48;
  localparam int         Q    = 20;
  localparam int         PH   = 6;
  logic             core_clk = 1'b0;
  logic             resetn   = 1'b0;
  logic             scl      = 1'b1;
  logic             hostSda  = 1'b1;
  logic             sdaOut;
  logic             sdaOe;
  logic             primaryAlarmOe;
  logic             secondaryAlarmOe;
  meas_req_s        measReq;
  meas_rsp_s        measRsp;
  logic [4:0][15:0] temps;
  logic [4:0]       opens;
  logic [2:0]       chLog[$];
  int               nFail;
  int               compares;
  int               cyc;
  int               doneAt;
  int               gap;
  word_t            v;
  // pull-up on the data wire: low only while someone drives it
  wire logic        sdaLine = sdaOe ? sdaOut : hostSda;

  temp_sensor_status_config #(.QUARTER_CYCLES(Q))
    temp_sensor_status_config_inst (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .scl              (scl),
    .sdaIn            (sdaLine),
    .sdaOut           (sdaOut),
    .sdaOe            (sdaOe),
    .measRsp          (measRsp),
    .measReq          (measReq),
    .primaryAlarmOe   (primaryAlarmOe),
    .secondaryAlarmOe (secondaryAlarmOe)
  );
  conv_model conv_model_inst (
    .core_clk (core_clk),
    .resetn   (resetn),
    .measReq  (measReq),
    .temps    (temps),
    .opens    (opens),
    .measRsp  (measRsp)
  );

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (measReq.start === 1'b1) begin
      chLog.push_back(measReq.channel);
      if (measReq.channel === 3'h0) gap = cyc - doneAt;
    end
    if (measRsp.done === 1'b1) doneAt = cyc;
  end

  // each bus phase lasts PH core clocks, well above the 2 needed
  task automatic phase(input logic s, input logic d);
    @(posedge core_clk);
    scl <= s;
    hostSda <= d;
    repeat (PH - 1) @(posedge core_clk);
  endtask
  task automatic i2c_start();
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    phase(1'b1, 1'b0);
    phase(1'b0, 1'b0);
  endtask
  task automatic i2c_stop();
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      phase(1'b0, b[i]);
      phase(1'b1, b[i]);
      phase(1'b0, b[i]);
    end
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    ack = ~sdaLine;
    phase(1'b0, 1'b1);
  endtask
  task automatic recv_byte(input logic ackIt, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      phase(1'b0, 1'b1);
      phase(1'b1, 1'b1);
      b[i] = sdaLine;
    end
    phase(1'b0, ~ackIt);
    phase(1'b1, ~ackIt);
    phase(1'b0, ~ackIt);
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input word_t d);
    logic [3:0] a;
    i2c_start();
    send_byte({ADDR, 1'b0}, a[3]);
    send_byte(ptr, a[2]);
    send_byte(d[15:8], a[1]);
    send_byte(d[7:0], a[0]);
    i2c_stop();
    `CHK("write acks", 4'hF, a)
  endtask
  task automatic rd_reg(input logic [7:0] ptr, input logic setPtr,
                        output word_t d);
    logic [2:0] a;
    a = 3'h7;
    if (setPtr) begin
      i2c_start();
      send_byte({ADDR, 1'b0}, a[0]);
      send_byte(ptr, a[1]);
    end
    i2c_start();
    send_byte({ADDR, 1'b1}, a[2]);
    recv_byte(1'b1, d[15:8]);
    recv_byte(1'b0, d[7:0]);
    i2c_stop();
    `CHK("read acks", 3'h7, a)
  endtask
  task automatic rchk(input logic [7:0] ptr, input word_t mask,
                      input word_t ex, input string nm);
    word_t d;
    rd_reg(ptr, 1'b1, d);
    `CHK(nm, ex, d & mask)
  endtask
  task automatic wait_starts(input int n);
    int k;
    chLog.delete();
    k = 0;
    while (chLog.size() < n && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    `CHK("start count", 1'b1, chLog.size() >= n)
  endtask
  task automatic check_order(input logic [14:0] ex, input int n);
    logic [14:0] got;
    int          i;
    wait_starts(n + 5);
    got = '0;
    i = 0;
    while (i < 5 && chLog[i] !== 3'h0) i++;
    for (int j = 0; j < n; j++) got = {got[11:0], chLog[i + j]};
    `CHK("channel order", ex, got)
  endtask
  task automatic idle_count(input int n, input int ex, input string nm);
    chLog.delete();
    repeat (n) @(posedge core_clk);
    `CHK(nm, ex, chLog.size())
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge core_clk);
    nFail++;
    complete_run();
  end

  initial begin
    temps = {16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h2000};
    opens = 5'h00;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    wait_starts(6);
    rd_reg(8'h00, 1'b0, v);
    `CHK("plain read", 16'h2000, v)
    rchk(8'h30, 16'hFFFD, 16'h0F9C, "config reset");
    rchk(8'h30, 16'h0002, 16'h0002, "busy running");
    check_order({3'h0, 3'h1, 3'h2, 3'h3, 3'h4}, 5);
    wr_reg(8'h39, 16'h1000);
    wr_reg(8'h3A, 16'h3000);
    wr_reg(8'h5A, 16'h0000);
    wr_reg(8'h5B, 16'h0000);
    wait_starts(7);
    rchk(8'h21, 16'hFFFF, 16'h0880, "alarm1");
    rchk(8'h22, 16'hFFFF, 16'h0800, "alarm2");
    `CHK("pins on", 2'h3, {primaryAlarmOe, secondaryAlarmOe})
    temps[0] <= 16'h0F81;
    wait_starts(7);
    rchk(8'h21, 16'hFFFF, 16'h0880, "alarm1 held");
    temps[0] <= 16'h0F7F;
    wait_starts(7);
    rchk(8'h21, 16'hFFFF, 16'h0800, "alarm1 clear");
    wr_reg(8'h5A, 16'h7FC0);
    wr_reg(8'h5B, 16'h7FC0);
    opens[1] <= 1'b1;
    wait_starts(7);
    rchk(8'h23, 16'hFFFF, 16'h0100, "open status");
    rchk(8'h01, 16'hFFFF, 16'h8000, "open temp");
    rchk(8'h21, 16'hFFFF, 16'h0000, "alarm1 idle");
    `CHK("pins off", 2'h0, {primaryAlarmOe, secondaryAlarmOe})
    wr_reg(8'h60, 16'h1234);
    rchk(8'h60, 16'hFFFF, 16'h0000, "unmapped");
    rchk(8'h30, 16'hFFFD, 16'h0F9C, "config kept");
    wr_reg(8'h38, 16'hFFFF);
    rchk(8'h38, 16'hFFFF, 16'h7FFF, "hysteresis");
    wr_reg(8'h30, 16'h0A9C);
    check_order({3'h0, 3'h2, 3'h4, 3'h0}, 4);
    rchk(8'h30, 16'hFFFD, 16'h0A9C, "enables");
    for (int r = 6; r >= 5; r--) begin
      wr_reg(8'h30, word_t'(16'h0F80 | (r << 2)));
      wait_starts(12);
      `CHK("rate gap", 1'b1,
           gap >= (Q << (6 - r)) && gap <= (Q << (6 - r)) + 3)
    end
    wr_reg(8'h30, 16'h001C);
    rchk(8'h30, 16'hFFFF, 16'h003C, "all off");
    idle_count(300, 0, "all off idle");
    wr_reg(8'h30, 16'h0F9C);
    wr_reg(8'h30, 16'h0FBE);
    repeat (300) @(posedge core_clk);
    rchk(8'h30, 16'hFFFF, 16'h0FBC, "shutdown");
    idle_count(300, 0, "shutdown idle");
    chLog.delete(); // the round starts before the write task returns
    wr_reg(8'h30, 16'h0FFC);
    repeat (400) @(posedge core_clk);
    `CHK("one-shot round", 5, chLog.size())
    rchk(8'h30, 16'hFFFF, 16'h0FBC, "one-shot done");
    complete_run();
  end
endmodule
